// ==== flash_suspend_otp_reset_cmds_tb_top.sv ====
// Self-checking bench for the suspend, security-area and reset command engine
module flash_suspend_otp_reset_cmds_tb_top import fsc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SUS_N = 40;
  localparam int RST_N = 200;
  typedef struct packed {logic [7:0] op; logic [3:0] st; logic [7:0] fwd;} fsc_row_t;
  fsc_row_t rows[9] = '{'{8'h06, 4'h4, 8'h00}, '{8'h75, 4'h4, 8'h00}, '{8'h7A, 4'h4, 8'h00},
    '{8'h03, 4'h4, 8'h03}, '{8'h04, 4'h0, 8'h03}, '{8'h66, 4'h0, 8'h03},
    '{8'h06, 4'h4, 8'h03}, '{8'h99, 4'h4, 8'h03}, '{8'h04, 4'h0, 8'h03}};
  logic [7:0] badOps[12] = '{8'h01, 8'h31, 8'h11, 8'h44, 8'h42, 8'h20, 8'h52, 8'hD8,
    8'hC7, 8'h60, 8'h02, 8'h32};
  logic [7:0] expRd[4] = '{8'hFF, 8'h55, 8'hAA, 8'hFF};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic dpdActive = 1'b0;
  logic [2:0] otpLock = 3'h0;
  logic mainPgmStart = 1'b0;
  logic mainErsStart = 1'b0;
  logic mainDone = 1'b0;
  logic csN;
  logic sclk;
  logic si;
  logic so;
  logic soOe;
  logic mainHold;
  logic mainAbort;
  logic softReset;
  logic cmdRefused;
  fsc_fwd_t fwdCmd;
  fsc_status_t status;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int refN = 0;
  int rstN = 0;
  int n;
  logic [7:0] lastFwd = 8'h00;
  logic [7:0] rx[$];
  fsc_host_model host (.csN(csN), .sclk(sclk), .si(si), .so(so));
  fsc_cmd_engine #(.SUS_CYC(SUS_N), .SEC_ERASE_CYC(1100), .SEC_PROG_CYC(300),
    .RST_CYC(RST_N)) dut (.core_clk(core_clk), .rst(rst), .sclk(sclk), .csN(csN), .si(si),
    .so(so), .soOe(soOe), .dpdActive(dpdActive), .otpLock(otpLock),
    .mainPgmStart(mainPgmStart), .mainErsStart(mainErsStart), .mainDone(mainDone),
    .mainHold(mainHold), .mainAbort(mainAbort), .softReset(softReset),
    .cmdRefused(cmdRefused), .fwdCmd(fwdCmd), .status(status));
  always #5 core_clk = ~core_clk;
  // Pulses are one cycle wide, so they are counted here
  always @(posedge core_clk) begin
    cyc++;
    if (cmdRefused === 1'b1) refN++;
    if (softReset === 1'b1 && mainAbort === 1'b1) rstN++;
    if (fwdCmd.valid === 1'b1) lastFwd = fwdCmd.opcode;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Step off the edge so registered status has settled
  task automatic chkSt(logic [3:0] exp);
    @(posedge core_clk);
    #2;
    chk("status", {4'h0, exp}, {4'h0, status});
  endtask : chkSt
  task automatic send(logic [7:0] tx[$]);
    host.frame(tx, 0, rx);
  endtask : send
  task automatic mainPulse(logic [2:0] p);
    @(posedge core_clk);
    #1 {mainErsStart, mainPgmStart, mainDone} = p;
    @(posedge core_clk);
    #1 {mainErsStart, mainPgmStart, mainDone} = 3'h0;
  endtask : mainPulse
  task automatic waitIdle;
    for (int i = 0; i < 3000 && status.writeInProgressFlag !== 1'b0; i++) @(posedge core_clk);
  endtask : waitIdle
  initial begin
    repeat (16) @(posedge core_clk);
    #1 rst = 1'b0;
    chkSt(4'h0);
    chk("soOe", 8'h00, {7'h0, soOe});
    foreach (rows[i]) begin
      send({rows[i].op});
      chkSt(rows[i].st);
      chk("fwd", rows[i].fwd, lastFwd);
    end
    chk("resets", 8'h00, 8'(rstN));
    mainPulse(3'h4);
    send({OP_PAUSE});
    chkSt(4'hA);
    chk("hold", 8'h01, {7'h0, mainHold});
    repeat (SUS_N) @(posedge core_clk);
    chkSt(4'h2);
    n = refN;
    send({OP_SEC_ERASE, 8'h00, 8'h10, 8'h00});
    send({8'h20, 8'h00, 8'h00, 8'h00});
    chk("refused", 8'(n + 2), 8'(refN));
    send({8'h02, 8'h00, 8'h00, 8'h00, 8'h00});
    chk("fwd", 8'h02, lastFwd);
    send({OP_CONTINUE});
    chkSt(4'h8);
    mainPulse(3'h1);
    mainPulse(3'h2);
    send({OP_PAUSE});
    repeat (SUS_N) @(posedge core_clk);
    chkSt(4'h1);
    n = refN;
    foreach (badOps[i]) send({badOps[i], 8'h00, 8'h10, 8'h00});
    chk("refused", 8'(n + 12), 8'(refN));
    send({OP_PAUSE});
    chkSt(4'h1);
    n = rstN;
    send({OP_RST_EN});
    send({OP_RST});
    chk("resets", 8'(n + 1), 8'(rstN));
    // Busy stands through the recovery time; latch and pause flags are gone
    chkSt(4'h8);
    n = refN;
    send({OP_SET_WE});
    chkSt(4'h8);
    chk("refused", 8'(n + 1), 8'(refN));
    repeat (RST_N) @(posedge core_clk);
    send({OP_SET_WE});
    send({OP_SEC_ERASE, 8'h00, 8'h10, 8'h00});
    chkSt(4'hC);
    waitIdle();
    chkSt(4'h0);
    send({OP_SET_WE});
    send({OP_SEC_PROG, 8'h00, 8'h13, 8'hFF, 8'h55});
    chkSt(4'hC);
    waitIdle();
    send({OP_SET_WE});
    send({OP_SEC_PROG, 8'h00, 8'h10, 8'h00, 8'hAA});
    waitIdle();
    host.frame({OP_SEC_READ, 8'h00, 8'h13, 8'hFE, 8'h00}, 4, rx);
    foreach (expRd[i]) chk("read", expRd[i], rx[i]);
    @(posedge core_clk);
    #1 otpLock = 3'h1;
    send({OP_SET_WE});
    send({OP_SEC_ERASE, 8'h00, 8'h10, 8'h00});
    chkSt(4'h4);
    send({OP_SEC_PROG, 8'h00, 8'h10, 8'h04, 8'h00});
    chkSt(4'h4);
    @(posedge core_clk);
    #1 otpLock = 3'h0;
    send({OP_SEC_ERASE, 8'h00, 8'h40, 8'h00});
    chkSt(4'h4);
    send({OP_SEC_ERASE, 8'h00, 8'h10, 8'h00, 8'h00});
    chkSt(4'h4);
    @(posedge core_clk);
    #1 dpdActive = 1'b1;
    n = refN;
    send({OP_CLR_WE});
    chkSt(4'h4);
    host.frame({OP_SEC_READ, 8'h00, 8'h10, 8'h00, 8'h00}, 1, rx);
    chk("refused", 8'(n + 2), 8'(refN));
    n = rstN;
    send({OP_RST_EN});
    send({OP_RST});
    chk("resets", 8'(n + 1), 8'(rstN));
    chkSt(4'h8);
    repeat (RST_N) @(posedge core_clk);
    chkSt(4'h0);
    tally_and_finish();
  end
endmodule : flash_suspend_otp_reset_cmds_tb_top

// ==== fsc_cmd_engine.sv ====
// Serial command engine: link-side shifter, read-out, and core-side command execution
module fsc_cmd_engine import fsc_pkg::*; #(
  parameter int SUS_CYC = SUS_CYC_DEF,
  parameter int SEC_ERASE_CYC = SEC_ERASE_CYC_DEF,
  parameter int SEC_PROG_CYC = SEC_PROG_CYC_DEF,
  parameter int RST_CYC = RST_CYC_DEF
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic si,
  output logic so,
  output logic soOe,
  input wire logic dpdActive,
  input wire logic [2:0] otpLock,
  input wire logic mainPgmStart,
  input wire logic mainErsStart,
  input wire logic mainDone,
  output logic mainHold,
  output logic mainAbort,
  output logic softReset,
  output logic cmdRefused,
  output fsc_fwd_t fwdCmd,
  output fsc_status_t status
);

  typedef struct packed {
    logic [7:0] shift;
    logic [2:0] bitCnt;
    logic [12:0] byteCnt;
    logic hdrDone;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic frameTgl;
    logic [PAGE_BYTES-1:0] pgValid;
  } fsc_link_t;

  typedef struct packed {
    fsc_state_t st;
    logic [1:0] csSync;
    logic [1:0] tglSync;
    logic csPrev;
    logic seenTgl;
    logic [23:0] timer;
    logic [10:0] idx;
    logic [1:0] area;
    logic [1:0] page;
    logic write_enable_latch;
    logic ersPaused;
    logic pgmPaused;
    logic mainIsPgm;
    logic mainIsErs;
    logic mainRun;
    logic susPending;
    logic [23:0] susCnt;
    logic rstEn;
    logic quiet;
    logic softRst;
    logic abortMain;
    logic refused;
    fsc_fwd_t fwd;
  } fsc_core_t;

  function automatic logic areaOk(input logic [23:0] a);
    areaOk = (a[23:16] == 8'h00) && (a[15:12] >= AREA_FIRST) && (a[15:12] <= AREA_LAST)
      && (a[11:10] == 2'b00);
  endfunction : areaOk

  function automatic logic [1:0] areaIdx(input logic [23:0] a);
    areaIdx = a[13:12] - 2'd1;
  endfunction : areaIdx

  function automatic logic isErase(input logic [7:0] op);
    isErase = (op == 8'h20) || (op == 8'h52) || (op == 8'hD8) || (op == 8'hC7) || (op == 8'h60);
  endfunction : isErase

  function automatic logic isStatusWrite(input logic [7:0] op);
    isStatusWrite = (op == 8'h01) || (op == 8'h31) || (op == 8'h11);
  endfunction : isStatusWrite

  // Storage of the three areas; the link side reads it in any read frame, even while an area cycle runs
  logic [7:0] secMem [3*AREA_BYTES];
  logic [7:0] pgBuf [PAGE_BYTES];

  fsc_link_t linkQ, linkD;
  fsc_core_t coreQ, coreD;
  logic inFrameQ;
  logic linkClr;
  logic soQ;
  logic readPhase;
  logic [9:0] rdPtr;
  logic [7:0] rdByte;
  logic [7:0] linkByte;
  logic linkDataByte;
  logic [7:0] linkCol;

  // ---------------- Link domain (host serial clock) ----------------
  assign linkClr = rst | csN;

  // Frame marker; select high clears it so the next rising edge starts a fresh frame
  always_ff @(posedge sclk or posedge linkClr) begin
    if (linkClr) begin
      inFrameQ <= 1'b0;
    end else begin
      inFrameQ <= 1'b1;
    end
  end

  always_comb begin
    linkD = linkQ;
    if (!inFrameQ) begin
      linkD.bitCnt = 3'd0;
      linkD.byteCnt = 13'd0;
      linkD.hdrDone = 1'b0;
      linkD.frameTgl = ~linkQ.frameTgl;
    end
    linkByte = {linkD.shift[6:0], si};
    linkDataByte = linkD.hdrDone || (linkD.byteCnt >= HDR_BYTES_ADDR);
    linkCol = linkD.addr[7:0] + 8'(linkD.byteCnt - HDR_BYTES_ADDR);
    linkD.shift = linkByte;
    if (linkD.bitCnt == 3'd7) begin
      if (linkD.byteCnt == 13'd0) begin
        linkD.opcode = linkByte;
        if (linkByte == OP_SEC_PROG) begin
          linkD.pgValid = '0;
        end
      end else if (!linkD.hdrDone && linkD.byteCnt < HDR_BYTES_ADDR) begin
        linkD.addr = {linkD.addr[15:0], linkByte};
      end else if (linkD.opcode == OP_SEC_PROG && linkDataByte) begin
        linkD.pgValid[linkCol] = 1'b1;
      end
      if (linkD.byteCnt == HDR_BYTES_READ) begin
        linkD.hdrDone = 1'b1;
      end
      linkD.byteCnt = linkD.byteCnt + 13'd1;
    end
    linkD.bitCnt = linkD.bitCnt + 3'd1;
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      linkQ <= '0;
    end else begin
      linkQ <= linkD;
    end
  end

  // Program data wraps inside the addressed page
  always_ff @(posedge sclk) begin
    if (linkD.bitCnt == 3'd0 && linkQ.opcode == OP_SEC_PROG && linkDataByte
        && (linkQ.byteCnt != 13'd0 || linkQ.hdrDone) && inFrameQ) begin
      pgBuf[linkCol] <= linkByte;
    end
  end

  // Read-out: byte index runs from the sixth byte, ten-bit pointer wraps
  assign readPhase = inFrameQ && (linkQ.opcode == OP_SEC_READ)
    && (linkQ.hdrDone || linkQ.byteCnt >= HDR_BYTES_READ);
  assign rdPtr = linkQ.addr[9:0] + 10'(linkQ.byteCnt - HDR_BYTES_READ);
  assign rdByte = areaOk(linkQ.addr) ? secMem[{areaIdx(linkQ.addr), rdPtr}] : ERASED_BYTE;

  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      soQ <= 1'b0;
    end else if (readPhase) begin
      soQ <= rdByte[3'd7 - linkQ.bitCnt];
    end
  end

  assign so = soQ;
  assign soOe = !csN && readPhase && !coreQ.quiet;

  // ---------------- Core domain ----------------
  logic csRise;
  logic newFrame;
  logic singleByte;
  logic addrOnly;
  logic hasData;
  logic pausedAny;
  logic [7:0] op;

  always_comb begin
    coreD = coreQ;
    coreD.csSync = {coreQ.csSync[0], csN};
    coreD.tglSync = {coreQ.tglSync[0], linkQ.frameTgl};
    coreD.csPrev = coreQ.csSync[1];
    coreD.softRst = 1'b0;
    coreD.abortMain = 1'b0;
    coreD.refused = 1'b0;
    coreD.fwd = '0;
    csRise = coreQ.csSync[1] && !coreQ.csPrev;
    newFrame = csRise && (coreQ.tglSync[1] != coreQ.seenTgl);
    // Frame words are stable here: the serial clock has stopped once select is high
    op = linkQ.opcode;
    singleByte = (linkQ.byteCnt == 13'd1) && !linkQ.hdrDone && (linkQ.bitCnt == 3'd0);
    addrOnly = (linkQ.byteCnt == HDR_BYTES_ADDR) && !linkQ.hdrDone && (linkQ.bitCnt == 3'd0);
    hasData = (linkQ.hdrDone || linkQ.byteCnt > HDR_BYTES_ADDR) && (linkQ.bitCnt == 3'd0);
    pausedAny = coreQ.ersPaused || coreQ.pgmPaused;

    // Main array engine bookkeeping
    if (mainPgmStart || mainErsStart) begin
      coreD.mainRun = 1'b1;
      coreD.mainIsPgm = mainPgmStart;
      coreD.mainIsErs = mainErsStart;
    end else if (mainDone && !pausedAny) begin
      coreD.mainRun = 1'b0;
      coreD.mainIsPgm = 1'b0;
      coreD.mainIsErs = 1'b0;
    end
    if (coreQ.susPending) begin
      if (coreQ.susCnt <= 24'd1) begin
        coreD.susPending = 1'b0;
        coreD.mainRun = 1'b0;
      end else begin
        coreD.susCnt = coreQ.susCnt - 24'd1;
      end
    end

    // Self-timed area cycles and reset recovery
    case (coreQ.st)
      ST_SEC_ERASE, ST_SEC_PROG: begin
        if (coreQ.idx != 11'h7FF) begin
          coreD.idx = coreQ.idx + 11'd1;
        end
        if (coreQ.timer == 24'd1) begin
          coreD.write_enable_latch = 1'b0;
        end
        if (coreQ.timer == 24'd0) begin
          coreD.st = ST_IDLE;
        end else begin
          coreD.timer = coreQ.timer - 24'd1;
        end
      end
      ST_RST_WAIT: begin
        if (coreQ.timer == 24'd0) begin
          coreD.st = ST_IDLE;
        end else begin
          coreD.timer = coreQ.timer - 24'd1;
        end
      end
      default: begin
      end
    endcase

    if (newFrame) begin
      coreD.seenTgl = coreQ.tglSync[1];
      coreD.rstEn = 1'b0;
      if (coreQ.st == ST_RST_WAIT) begin
        coreD.refused = 1'b1;
      end else if (dpdActive && op != OP_DPD_EXIT && op != OP_RST_EN && op != OP_RST) begin
        coreD.refused = 1'b1;
      end else if (op == OP_RST_EN) begin
        coreD.rstEn = singleByte;
      end else if (op == OP_RST) begin
        if (singleByte && coreQ.rstEn) begin
          coreD.st = ST_RST_WAIT;
          coreD.timer = 24'(RST_CYC);
          coreD.write_enable_latch = 1'b0;
          coreD.ersPaused = 1'b0;
          coreD.pgmPaused = 1'b0;
          coreD.susPending = 1'b0;
          coreD.mainRun = 1'b0;
          coreD.mainIsPgm = 1'b0;
          coreD.mainIsErs = 1'b0;
          coreD.softRst = 1'b1;
          coreD.abortMain = 1'b1;
        end
      end else if (op == OP_PAUSE) begin
        if (!pausedAny && coreQ.mainRun && (coreQ.mainIsPgm || coreQ.mainIsErs)
            && coreQ.st == ST_IDLE) begin
          coreD.pgmPaused = coreQ.mainIsPgm;
          coreD.ersPaused = coreQ.mainIsErs;
          coreD.susPending = 1'b1;
          coreD.susCnt = 24'(SUS_CYC);
        end
      end else if (op == OP_CONTINUE) begin
        if (pausedAny && !coreQ.mainRun) begin
          coreD.pgmPaused = 1'b0;
          coreD.ersPaused = 1'b0;
          coreD.mainRun = 1'b1;
        end
      end else if (op == OP_SET_WE) begin
        coreD.write_enable_latch = 1'b1;
      end else if (op == OP_CLR_WE) begin
        coreD.write_enable_latch = 1'b0;
      end else if (op == OP_SEC_ERASE) begin
        if (pausedAny) begin
          coreD.refused = 1'b1;
        end else if (addrOnly && coreQ.write_enable_latch && areaOk(linkQ.addr) && coreQ.st == ST_IDLE
                     && !coreQ.mainRun && !otpLock[areaIdx(linkQ.addr)]) begin
          coreD.st = ST_SEC_ERASE;
          coreD.timer = 24'(SEC_ERASE_CYC);
          coreD.idx = '0;
          coreD.area = areaIdx(linkQ.addr);
        end
      end else if (op == OP_SEC_PROG) begin
        if (coreQ.pgmPaused) begin
          coreD.refused = 1'b1;
        end else if (hasData && coreQ.write_enable_latch && areaOk(linkQ.addr) && coreQ.st == ST_IDLE
                     && !coreQ.mainRun && !otpLock[areaIdx(linkQ.addr)]) begin
          coreD.st = ST_SEC_PROG;
          coreD.timer = 24'(SEC_PROG_CYC);
          coreD.idx = '0;
          coreD.area = areaIdx(linkQ.addr);
          coreD.page = linkQ.addr[9:8];
        end
      end else if (op == OP_SEC_READ) begin
        coreD.fwd = '0;
      end else if (coreQ.pgmPaused && (isStatusWrite(op) || isErase(op)
                   || op == 8'h02 || op == 8'h32)) begin
        coreD.refused = 1'b1;
      end else if (coreQ.ersPaused && (isStatusWrite(op) || isErase(op))) begin
        coreD.refused = 1'b1;
      end else begin
        coreD.fwd.valid = 1'b1;
        coreD.fwd.opcode = op;
      end
    end
    coreD.quiet = dpdActive || (coreD.st == ST_RST_WAIT);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      coreQ <= '{st: ST_IDLE, csSync: 2'b11, csPrev: 1'b1, default: '0};
    end else begin
      coreQ <= coreD;
    end
  end

  // Array updates; programming can only clear bits, as the cells do
  always_ff @(posedge core_clk) begin
    if (coreQ.st == ST_SEC_ERASE && coreQ.idx < 11'(AREA_BYTES)) begin
      secMem[{coreQ.area, coreQ.idx[9:0]}] <= ERASED_BYTE;
    end else if (coreQ.st == ST_SEC_PROG && coreQ.idx < 11'(PAGE_BYTES)
                 && linkQ.pgValid[coreQ.idx[7:0]]) begin
      secMem[{coreQ.area, coreQ.page, coreQ.idx[7:0]}] <=
        secMem[{coreQ.area, coreQ.page, coreQ.idx[7:0]}] & pgBuf[coreQ.idx[7:0]];
    end
  end

  assign status.writeInProgressFlag = coreQ.mainRun || (coreQ.st != ST_IDLE);
  assign status.writeEnableLatch = coreQ.write_enable_latch;
  assign status.erasePausedFlag = coreQ.ersPaused;
  assign status.programPausedFlag = coreQ.pgmPaused;
  assign mainHold = coreQ.ersPaused || coreQ.pgmPaused;
  assign mainAbort = coreQ.abortMain;
  assign softReset = coreQ.softRst;
  assign cmdRefused = coreQ.refused;
  assign fwdCmd = coreQ.fwd;

endmodule : fsc_cmd_engine

// ==== fsc_cmd_engine_assertions.sv ====
// Checker for the suspend, security-area and reset command engine
module fsc_cmd_engine_chk import fsc_pkg::*; #(
  parameter int SUS_CYC = 40
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic csN,
  input wire logic soOe,
  input wire logic dpdActive,
  input wire logic mainHold,
  input wire logic mainAbort,
  input wire logic softReset,
  input wire logic cmdRefused,
  input wire fsc_fwd_t fwdCmd,
  input wire fsc_status_t status
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SUS_MAX = SUS_CYC + 2;
  localparam int RES_MAX = RESUME_CYC;
  logic anyPause;
  assign anyPause = status.erasePausedFlag | status.programPausedFlag;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // A pause may only rise out of a busy, unpaused main operation
  property p_hold;
    (mainHold == anyPause)
      && (!$rose(mainHold) || ($past(status.writeInProgressFlag) && !$past(anyPause)));
  endproperty
  a_hold: assert property (p_hold) else $error("hold differs from pause flags");
  property p_excl; !(status.erasePausedFlag && status.programPausedFlag); endproperty
  a_excl: assert property (p_excl) else $error("both pause flags set");
  property p_busy; $rose(anyPause) |-> status.writeInProgressFlag [*8]; endproperty
  a_busy: assert property (p_busy) else $error("pause without busy");
  property p_drop; $rose(anyPause) |-> ##[1:SUS_MAX] !status.writeInProgressFlag; endproperty
  a_drop: assert property (p_drop) else $error("busy not cleared after pause");
  property p_res;
    $fell(anyPause) && !softReset && !$past(softReset) |-> ##[0:RES_MAX]
      status.writeInProgressFlag;
  endproperty
  a_res: assert property (p_res) else $error("busy not set after resume");
  property p_so; soOe |-> !csN && !dpdActive; endproperty
  a_so: assert property (p_so) else $error("output driven while deselected");
  property p_abort; softReset |-> mainAbort && !mainHold && !status.writeEnableLatch; endproperty
  a_abort: assert property (p_abort) else $error("reset without abort");
  property p_clr; softReset |=> !status.writeEnableLatch && !anyPause; endproperty
  a_clr: assert property (p_clr) else $error("state kept over reset");
  // Only a software reset may move the latch while powered down
  property p_dpd; $changed(status.writeEnableLatch) |-> !dpdActive || softReset; endproperty
  a_dpd: assert property (p_dpd) else $error("latch set in power-down");
  property p_ref; cmdRefused |-> !fwdCmd.valid ##1 !cmdRefused; endproperty
  a_ref: assert property (p_ref) else $error("refused frame passed on");
endmodule : fsc_cmd_engine_chk

bind fsc_cmd_engine fsc_cmd_engine_chk #(.SUS_CYC(SUS_CYC)) u_chk (
  .core_clk(core_clk),
  .rst(rst),
  .csN(csN),
  .soOe(soOe),
  .dpdActive(dpdActive),
  .mainHold(mainHold),
  .mainAbort(mainAbort),
  .softReset(softReset),
  .cmdRefused(cmdRefused),
  .fwdCmd(fwdCmd),
  .status(status)
);

// ==== fsc_host_model.sv ====
// Host serial controller model driving select, clock and data
module fsc_host_model (
  output logic csN,
  output logic sclk,
  output logic si,
  input wire logic so
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    si = 1'b1;
  end
  // Clock only runs inside a frame, 30 ns period
  task automatic frame(input logic [7:0] tx[$], input int nRd, output logic [7:0] rx[$]);
    logic [7:0] b;
    int i;
    int k;
    rx = {};
    csN = 1'b0;
    for (i = 0; i < tx.size() + nRd; i++) begin
      for (k = 7; k >= 0; k--) begin
        si = (i < tx.size()) ? tx[i][k] : ~si;
        #15 sclk = 1'b1;
        b[k] = so;
        #15 sclk = 1'b0;
      end
      if (i >= tx.size()) rx.push_back(b);
    end
    // Released line must not keep its last bit
    si = ~si;
    #15 csN = 1'b1;
    #200;
  endtask : frame
endmodule : fsc_host_model

// ==== fsc_pkg.sv ====
// Shared constants and carrier types for the flash suspend, security-area and reset commands
package fsc_pkg;
  localparam logic [7:0] OP_PAUSE = 8'h75;
  localparam logic [7:0] OP_CONTINUE = 8'h7A;
  localparam logic [7:0] OP_SET_WE = 8'h06;
  localparam logic [7:0] OP_CLR_WE = 8'h04;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  localparam logic [7:0] OP_SEC_PROG = 8'h42;
  localparam logic [7:0] OP_SEC_READ = 8'h48;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_DPD_EXIT = 8'hAB;
  localparam logic [3:0] AREA_FIRST = 4'h1;
  localparam logic [3:0] AREA_LAST = 4'h3;
  localparam int AREA_BYTES = 1024;
  localparam int PAGE_BYTES = 256;
  localparam logic [12:0] HDR_BYTES_ADDR = 13'h0004;
  localparam logic [12:0] HDR_BYTES_READ = 13'h0005;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_RESUME_NS = 200;
  localparam int RESUME_CYC = (T_RESUME_NS / CLK_PERIOD_NS) < 1 ? 1 : T_RESUME_NS / CLK_PERIOD_NS;
  localparam int T_SUS_US = 40;
  localparam int T_SEC_ERASE_US = 2000;
  localparam int T_SEC_PROG_US = 600;
  localparam int T_RST_US = 30;
  localparam int SUS_CYC_DEF = T_SUS_US * 1000 / CLK_PERIOD_NS;
  localparam int SEC_ERASE_CYC_DEF = T_SEC_ERASE_US * 1000 / CLK_PERIOD_NS;
  localparam int SEC_PROG_CYC_DEF = T_SEC_PROG_US * 1000 / CLK_PERIOD_NS;
  localparam int RST_CYC_DEF = T_RST_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SEC_ERASE = 4'h2,
    ST_SEC_PROG = 4'h4,
    ST_RST_WAIT = 4'h8
  } fsc_state_t;

  typedef struct packed {
    logic writeInProgressFlag;
    logic writeEnableLatch;
    logic erasePausedFlag;
    logic programPausedFlag;
  } fsc_status_t;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
  } fsc_fwd_t;
endpackage : fsc_pkg
